// file: inc/lwc_pkg.sv
// Shared constants for the line window check block.
// Assumes a 32-bit classic Wishbone bus with byte addressing.
package lwc_pkg;
	// Coordinate width, signed
	localparam int CW = 16;
	// Register byte offsets
	localparam logic [7:0] A_CTRL  = 8'h00;
	localparam logic [7:0] A_WSTA  = 8'h04;
	localparam logic [7:0] A_WEND  = 8'h08;
	localparam logic [7:0] A_PT0   = 8'h0C;
	localparam logic [7:0] A_PT1   = 8'h10;
	localparam logic [7:0] A_CMD   = 8'h14;
	localparam logic [7:0] A_STAT  = 8'h18;
	localparam logic [7:0] A_CODE  = 8'h1C;
	localparam logic [7:0] A_CUR   = 8'h20;
	localparam logic [7:0] A_DELTA = 8'h24;
	// Control fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_FEN_BIT  = 2;
	localparam int CTRL_IE_BIT   = 3;
	// Command bits
	localparam int CMD_LINE_BIT  = 0;
	localparam int CMD_CPW_BIT   = 1;
	localparam int CMD_SETUP_BIT = 2;
	// Status bits
	localparam int ST_OUT_BIT  = 0;
	localparam int ST_VERT_BIT = 1;
	localparam int ST_ALL_BIT  = 2;
	localparam int ST_FLAT_BIT = 3;
	localparam int ST_PEND_BIT = 4;
	localparam int ST_BUSY_BIT = 5;
	// Outcode bit positions
	localparam int OC_LEFT  = 0;
	localparam int OC_RIGHT = 1;
	localparam int OC_LOW   = 2;
	localparam int OC_HIGH  = 3;
	// Reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [3:0]  OC_INSIDE = 4'h0;

	// Window checking modes
	typedef enum logic [1:0] {
		LWC_OFF  = 2'b00,
		LWC_HIT  = 2'b01,
		LWC_MISS = 2'b10,
		LWC_CLIP = 2'b11
	} lwc_mode_t;

	// Region code of a point; signed inclusive limits
	function automatic logic [3:0] lwc_outcode(
		input logic signed [CW-1:0] x,
		input logic signed [CW-1:0] y,
		input logic signed [CW-1:0] xs,
		input logic signed [CW-1:0] ys,
		input logic signed [CW-1:0] xe,
		input logic signed [CW-1:0] ye
	);
		logic [3:0] c;
		c = OC_INSIDE;
		c[OC_LEFT]  = (x < xs);
		c[OC_RIGHT] = (x > xe);
		c[OC_LOW]   = (y < ys);
		c[OC_HIGH]  = (y > ye);
		return c;
	endfunction : lwc_outcode
endpackage : lwc_pkg

// file: core/lwc_pixel_gate.sv
// Per-pixel window test and write gate for the line engine.
// Assumes point and window come from registers on the same clock.
`timescale 1ns/1ps
module lwc_pixel_gate (
	input  wire logic signed [lwc_pkg::CW-1:0] x_in,
	input  wire logic signed [lwc_pkg::CW-1:0] y_in,
	input  wire logic signed [lwc_pkg::CW-1:0] xs_in,
	input  wire logic signed [lwc_pkg::CW-1:0] ys_in,
	input  wire logic signed [lwc_pkg::CW-1:0] xe_in,
	input  wire logic signed [lwc_pkg::CW-1:0] ye_in,
	input  wire logic [1:0]                    mode_in,
	output logic                               inside_out,
	output logic                               write_out,
	output logic                               viol_out
);
	import lwc_pkg::*;

	logic [3:0] code;

	assign code       = lwc_outcode(x_in, y_in, xs_in, ys_in, xe_in, ye_in);
	assign inside_out = (code == OC_INSIDE);

	// Gate is pure logic, so it costs no pixel time
	always_comb begin
		write_out = 1'b0;
		viol_out  = 1'b0;
		case (mode_in)
			LWC_OFF: write_out = 1'b1;
			LWC_HIT: viol_out = inside_out;
			LWC_MISS: begin
				write_out = inside_out;
				viol_out  = !inside_out;
			end
			LWC_CLIP: write_out = inside_out;
			default: write_out = 1'b0;
		endcase
	end
endmodule : lwc_pixel_gate

// file: core/lwc_line_setup.sv
// Line setup: step operands and status from two endpoints.
// Assumes endpoints and window are held stable in registers.
`timescale 1ns/1ps
module lwc_line_setup (
	input  wire logic signed [lwc_pkg::CW-1:0] x0_in,
	input  wire logic signed [lwc_pkg::CW-1:0] y0_in,
	input  wire logic signed [lwc_pkg::CW-1:0] x1_in,
	input  wire logic signed [lwc_pkg::CW-1:0] y1_in,
	input  wire logic signed [lwc_pkg::CW-1:0] xs_in,
	input  wire logic signed [lwc_pkg::CW-1:0] ys_in,
	input  wire logic signed [lwc_pkg::CW-1:0] xe_in,
	input  wire logic signed [lwc_pkg::CW-1:0] ye_in,
	output logic [lwc_pkg::CW:0]               dx_out,
	output logic [lwc_pkg::CW:0]               dy_out,
	output logic                               xneg_out,
	output logic                               yneg_out,
	output logic                               vert_out,
	output logic                               flat_out,
	output logic                               allout_out,
	output logic                               out_out
);
	import lwc_pkg::*;

	logic signed [CW:0] ddx;
	logic signed [CW:0] ddy;
	logic [3:0]         c0;
	logic [3:0]         c1;

	assign ddx      = {x1_in[CW-1], x1_in} - {x0_in[CW-1], x0_in};
	assign ddy      = {y1_in[CW-1], y1_in} - {y0_in[CW-1], y0_in};
	assign xneg_out = ddx[CW];
	assign yneg_out = ddy[CW];
	assign dx_out   = ddx[CW] ? (CW+1)'(0) - ddx : ddx;
	assign dy_out   = ddy[CW] ? (CW+1)'(0) - ddy : ddy;

	assign c0 = lwc_outcode(x0_in, y0_in, xs_in, ys_in, xe_in, ye_in);
	assign c1 = lwc_outcode(x1_in, y1_in, xs_in, ys_in, xe_in, ye_in);

	assign vert_out   = (x0_in == x1_in);
	assign flat_out   = (y0_in == y1_in);
	assign allout_out = ((c0 & c1) != OC_INSIDE);
	assign out_out    = (c0 != OC_INSIDE) || (c1 != OC_INSIDE);
endmodule : lwc_line_setup

// file: core/lwc_top.sv
// Window checking and line clipping engine with Wishbone registers.
// Assumes a classic Wishbone master on clk_in and a pixel writer
// that accepts one pixel per cycle on pix_we_out.
//
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/1ps

module lwc_top (
	input  wire logic                   clk_in,
	input  wire logic                   rst_n_in,
	input  wire logic                   ce_in,
	input  wire logic                   wb_cyc_in,
	input  wire logic                   wb_stb_in,
	input  wire logic                   wb_we_in,
	input  wire logic [7:0]             wb_adr_in,
	input  wire logic [3:0]             wb_sel_in,
	input  wire logic [31:0]            wb_dat_in,
	output logic [31:0]                 wb_dat_out,
	output logic                        wb_ack_out,
	output logic                        pix_we_out,
	output logic [lwc_pkg::CW-1:0]      pix_x_out,
	output logic [lwc_pkg::CW-1:0]      pix_y_out,
	output logic                        line_done_out,
	output logic                        fault_irq_out
);
	import lwc_pkg::*;

	typedef enum logic {
		LWC_IDLE = 1'b0,
		LWC_RUN  = 1'b1
	} lwc_state_t;

	// Byte-lane merge of a write into a register word
	function automatic logic [31:0] lwc_merge(
		input logic [31:0] old,
		input logic [31:0] nw,
		input logic [3:0]  sel
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : lwc_merge

	////////////////////////////////////////////////////////////////
	// Registers and engine state
	////////////////////////////////////////////////////////////////
	logic [31:0]        ctrl;
	logic [31:0]        wsta;
	logic [31:0]        wend;
	logic [31:0]        pt0;
	logic [31:0]        pt1;
	logic [3:0]         code;
	logic [31:0]        delta;
	logic               f_out;
	logic               f_vert;
	logic               f_all;
	logic               f_flat;
	logic               f_pend;
	lwc_state_t         state;
	logic [1:0]         lmode;
	logic signed [CW-1:0] cx;
	logic signed [CW-1:0] cy;
	logic signed [CW-1:0] ex;
	logic signed [CW-1:0] ey;
	logic signed [CW+3:0] err;
	logic signed [CW+3:0] sdx;
	logic signed [CW+3:0] sdy;
	logic               sxn;
	logic               syn;

	logic               req;
	logic               wr;
	logic               cmd_line;
	logic               cmd_cpw;
	logic               cmd_setup;
	logic               clr_pend;
	logic               busy;

	// Window limits and endpoints, low half X, high half Y
	logic signed [CW-1:0] xs;
	logic signed [CW-1:0] ys;
	logic signed [CW-1:0] xe;
	logic signed [CW-1:0] ye;
	logic signed [CW-1:0] x0;
	logic signed [CW-1:0] y0;
	logic signed [CW-1:0] x1;
	logic signed [CW-1:0] y1;

	assign xs = wsta[CW-1:0];
	assign ys = wsta[31:CW];
	assign xe = wend[CW-1:0];
	assign ye = wend[31:CW];
	assign x0 = pt0[CW-1:0];
	assign y0 = pt0[31:CW];
	assign x1 = pt1[CW-1:0];
	assign y1 = pt1[31:CW];

	////////////////////////////////////////////////////////////////
	// Bus decode
	////////////////////////////////////////////////////////////////
	// New request only when no ack is standing
	assign req       = wb_cyc_in && wb_stb_in && !wb_ack_out;
	assign wr        = req && wb_we_in;
	assign cmd_line  = wr && wb_adr_in == A_CMD && wb_sel_in[0]
		&& wb_dat_in[CMD_LINE_BIT];
	assign cmd_cpw   = wr && wb_adr_in == A_CMD && wb_sel_in[0]
		&& wb_dat_in[CMD_CPW_BIT];
	assign cmd_setup = wr && wb_adr_in == A_CMD && wb_sel_in[0]
		&& wb_dat_in[CMD_SETUP_BIT];
	assign clr_pend  = wr && wb_adr_in == A_STAT && wb_sel_in[0]
		&& wb_dat_in[ST_PEND_BIT];
	assign busy      = (state == LWC_RUN);

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wb_ack_out <= 1'b0;
		end else if (ce_in) begin
			wb_ack_out <= req;
		end
	end

	// Read data registered with the ack; unmapped reads zero
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wb_dat_out <= RST_WORD;
		end else if (ce_in && req) begin
			case (wb_adr_in)
				A_CTRL:  wb_dat_out <= {28'h0000000, ctrl[3:0]};
				A_WSTA:  wb_dat_out <= wsta;
				A_WEND:  wb_dat_out <= wend;
				A_PT0:   wb_dat_out <= pt0;
				A_PT1:   wb_dat_out <= pt1;
				A_CMD:   wb_dat_out <= {31'h00000000, busy};
				A_STAT:  wb_dat_out <= {26'h0000000, busy, f_pend,
					f_flat, f_all, f_vert, f_out};
				A_CODE:  wb_dat_out <= {28'h0000000, code};
				A_CUR:   wb_dat_out <= {cy, cx};
				A_DELTA: wb_dat_out <= delta;
				default: wb_dat_out <= RST_WORD;
			endcase
		end
	end

	// Plain storage registers, byte lanes honoured
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl <= RST_WORD;
			wsta <= RST_WORD;
			wend <= RST_WORD;
			pt0  <= RST_WORD;
			pt1  <= RST_WORD;
		end else if (ce_in && wr) begin
			case (wb_adr_in)
				A_CTRL: ctrl <= lwc_merge(ctrl, wb_dat_in, wb_sel_in);
				A_WSTA: wsta <= lwc_merge(wsta, wb_dat_in, wb_sel_in);
				A_WEND: wend <= lwc_merge(wend, wb_dat_in, wb_sel_in);
				A_PT0:  pt0  <= lwc_merge(pt0, wb_dat_in, wb_sel_in);
				A_PT1:  pt1  <= lwc_merge(pt1, wb_dat_in, wb_sel_in);
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Setup and per-pixel check
	////////////////////////////////////////////////////////////////
	logic [CW:0] s_dx;
	logic [CW:0] s_dy;
	logic        s_xneg;
	logic        s_yneg;
	logic        s_vert;
	logic        s_flat;
	logic        s_all;
	logic        s_out;
	logic        g_in;
	logic        g_wr;
	logic        g_viol;

	lwc_line_setup u_setup (
		.x0_in      (x0),
		.y0_in      (y0),
		.x1_in      (x1),
		.y1_in      (y1),
		.xs_in      (xs),
		.ys_in      (ys),
		.xe_in      (xe),
		.ye_in      (ye),
		.dx_out     (s_dx),
		.dy_out     (s_dy),
		.xneg_out   (s_xneg),
		.yneg_out   (s_yneg),
		.vert_out   (s_vert),
		.flat_out   (s_flat),
		.allout_out (s_all),
		.out_out    (s_out)
	);

	lwc_pixel_gate u_gate (
		.x_in       (cx),
		.y_in       (cy),
		.xs_in      (xs),
		.ys_in      (ys),
		.xe_in      (xe),
		.ye_in      (ye),
		.mode_in    (lmode),
		.inside_out (g_in),
		.write_out  (g_wr),
		.viol_out   (g_viol)
	);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			code <= OC_INSIDE;
		end else if (ce_in && cmd_cpw) begin
			code <= lwc_outcode(x0, y0, xs, ys, xe, ye);
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			delta <= RST_WORD;
		end else if (ce_in && cmd_setup) begin
			delta <= {s_dy[CW-1:0], s_dx[CW-1:0]};
		end
	end

	////////////////////////////////////////////////////////////////
	// Line stepper
	////////////////////////////////////////////////////////////////
	logic signed [CW+4:0] e2;
	logic                 last;
	logic                 stop;
	assign e2   = {err, 1'b0};
	assign last = (cx == ex) && (cy == ey);
	// Abort on violation or finish on the endpoint
	assign stop = busy && (g_viol || last);

	// State: start ignored while a line is running
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= LWC_IDLE;
		end else if (ce_in) begin
			case (state)
				LWC_IDLE: if (cmd_line) begin
					state <= LWC_RUN;
				end
				LWC_RUN: if (stop) begin
					state <= LWC_IDLE;
				end
				default: state <= LWC_IDLE;
			endcase
		end
	end

	// Stepping registers; abort leaves them at the offending point
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lmode <= LWC_OFF;
			cx    <= '0;
			cy    <= '0;
			ex    <= '0;
			ey    <= '0;
			err   <= '0;
			sdx   <= '0;
			sdy   <= '0;
			sxn   <= 1'b0;
			syn   <= 1'b0;
		end else if (ce_in) begin
			if (!busy && cmd_line) begin
				lmode <= ctrl[CTRL_MODE_LSB +: 2];
				cx    <= x0;
				cy    <= y0;
				ex    <= x1;
				ey    <= y1;
				sdx   <= (CW+4)'(s_dx);
				sdy   <= (CW+4)'(s_dy);
				err   <= (CW+4)'(s_dx) - (CW+4)'(s_dy);
				sxn   <= s_xneg;
				syn   <= s_yneg;
			end else if (busy && !stop) begin
				if (e2 >= -(CW+5)'(sdy) && e2 <= (CW+5)'(sdx)) begin
					err <= err - sdy + sdx;
				end else if (e2 >= -(CW+5)'(sdy)) begin
					err <= err - sdy;
				end else if (e2 <= (CW+5)'(sdx)) begin
					err <= err + sdx;
				end
				if (e2 >= -(CW+5)'(sdy)) begin
					cx <= sxn ? cx - 1'b1 : cx + 1'b1;
				end
				if (e2 <= (CW+5)'(sdx)) begin
					cy <= syn ? cy - 1'b1 : cy + 1'b1;
				end
			end
		end
	end

	// Pixel port registered; one point per cycle
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pix_we_out    <= 1'b0;
			pix_x_out     <= '0;
			pix_y_out     <= '0;
			line_done_out <= 1'b0;
		end else if (ce_in) begin
			pix_we_out    <= busy && g_wr;
			pix_x_out     <= cx;
			pix_y_out     <= cy;
			line_done_out <= stop;
		end
	end

	////////////////////////////////////////////////////////////////
	// Status flags and fault
	////////////////////////////////////////////////////////////////
	// Last writer wins: line end after setup in the same cycle
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			f_out  <= 1'b0;
			f_vert <= 1'b0;
			f_all  <= 1'b0;
			f_flat <= 1'b0;
		end else if (ce_in) begin
			if (cmd_setup) begin
				f_vert <= s_vert;
				f_all  <= s_all;
				f_flat <= s_flat;
				f_out  <= s_out;
			end
			if (stop) begin
				case (lmode)
					LWC_HIT:  f_out <= !g_viol;
					LWC_MISS: f_out <= g_viol;
					LWC_CLIP: f_out <= !g_in;
					default:  f_out <= f_out;
				endcase
			end
		end
	end

	// pending; a set beats a clear
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			f_pend <= 1'b0;
		end else if (ce_in) begin
			if (busy && g_viol) begin
				f_pend <= 1'b1;
			end else if (clr_pend) begin
				f_pend <= 1'b0;
			end
		end
	end

	assign fault_irq_out = f_pend && ctrl[CTRL_FEN_BIT] && ctrl[CTRL_IE_BIT];
endmodule : lwc_top

// file: test/lwc_top_properties.sv
// Port-level checks for the line window engine.
// Assumes control and window are written with full byte enables.
`timescale 1ns/1ps
module lwc_chk (
	input  wire logic                   clk_in,
	input  wire logic                   rst_n_in,
	input  wire logic                   ce_in,
	input  wire logic                   wb_cyc_in,
	input  wire logic                   wb_stb_in,
	input  wire logic                   wb_we_in,
	input  wire logic [7:0]             wb_adr_in,
	input  wire logic [3:0]             wb_sel_in,
	input  wire logic [31:0]            wb_dat_in,
	input  wire logic                   wb_ack_out,
	input  wire logic                   pix_we_out,
	input  wire logic [lwc_pkg::CW-1:0] pix_x_out,
	input  wire logic [lwc_pkg::CW-1:0] pix_y_out,
	input  wire logic                   line_done_out,
	input  wire logic                   fault_irq_out
);
	import lwc_pkg::*;
	////////////////////////////////////////////////////////////////
	logic                 take;
	logic                 wr;
	logic                 start;
	logic                 ins;
	logic                 mask;
	logic                 busy;
	logic                 fen;
	logic                 ien;
	logic [1:0]           cmode;
	logic [1:0]           rmode;
	logic signed [CW-1:0] xs;
	logic signed [CW-1:0] ys;
	logic signed [CW-1:0] xe;
	logic signed [CW-1:0] ye;
	// Decoded bus events and window test of the presented pixel
	assign take  = wb_cyc_in && wb_stb_in && !wb_ack_out && ce_in;
	assign wr    = take && wb_we_in && (wb_sel_in == 4'hF);
	assign start = wr && (wb_adr_in == A_CMD) && wb_dat_in[CMD_LINE_BIT] && !busy;
	assign mask  = fen && ien;
	assign ins   = ($signed(pix_x_out) >= xs) && ($signed(pix_x_out) <= xe)
		&& ($signed(pix_y_out) >= ys) && ($signed(pix_y_out) <= ye);
	// Shadow of control and window; mode latched at start like the engine
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			{cmode, rmode, fen, ien, busy} <= '0;
			{xs, ys, xe, ye} <= '0;
		end else begin
			if (wr && wb_adr_in == A_CTRL) begin
				cmode <= wb_dat_in[1:0];
				fen   <= wb_dat_in[CTRL_FEN_BIT];
				ien   <= wb_dat_in[CTRL_IE_BIT];
			end
			if (wr && wb_adr_in == A_WSTA) begin
				{ys, xs} <= wb_dat_in;
			end
			if (wr && wb_adr_in == A_WEND) begin
				{ye, xe} <= wb_dat_in;
			end
			if (start) begin
				busy  <= 1'b1;
				rmode <= cmode;
			end else if (line_done_out) begin
				busy <= 1'b0;
			end
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	AST_ACK_TAKEN: assert property (take |=> wb_ack_out)
		else $error("request not acknowledged next cycle");
	AST_ACK_PULSE: assert property (wb_ack_out && ce_in |=> !wb_ack_out)
		else $error("acknowledge longer than one cycle");
	AST_HIT_NO_WRITE: assert property (rmode == LWC_HIT |-> !pix_we_out)
		else $error("pixel written in hit mode");
	AST_OFF_FIRST_PIX: assert property (start && cmode == LWC_OFF |-> ##2 pix_we_out)
		else $error("first point not drawn with checking off");
	AST_OFF_DONE_DRAWN: assert property (rmode == LWC_OFF && line_done_out |-> pix_we_out)
		else $error("last point not drawn with checking off");
	AST_MISS_INSIDE: assert property (rmode == LWC_MISS && pix_we_out |-> ins)
		else $error("outside pixel drawn in miss mode");
	AST_CLIP_INSIDE: assert property (rmode == LWC_CLIP && pix_we_out |-> ins)
		else $error("outside pixel drawn in clip mode");
	AST_IRQ_MASKED: assert property (!mask && !$past(mask) |-> !fault_irq_out)
		else $error("interrupt raised while masked");
	AST_MISS_ABORT_IRQ: assert property (rmode == LWC_MISS && line_done_out && !pix_we_out
		&& mask |-> ##[0:1] fault_irq_out)
		else $error("miss abort raised no interrupt");
endmodule : lwc_chk

bind lwc_top lwc_chk u_chk (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .wb_cyc_in(wb_cyc_in),
	.wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
	.wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_ack_out(wb_ack_out),
	.pix_we_out(pix_we_out), .pix_x_out(pix_x_out), .pix_y_out(pix_y_out),
	.line_done_out(line_done_out), .fault_irq_out(fault_irq_out)
);

// file: test/lwc_top_tb.sv
// Self-checking bench for the line window engine.
// Assumes the port checker is bound to the design elsewhere.
`timescale 1ns/1ps
module lwc_top_tb;
	import lwc_pkg::*;
	logic          clk_in;
	logic          rst_n_in;
	logic          ce_in;
	logic          wb_cyc_in;
	logic          wb_stb_in;
	logic          wb_we_in;
	logic [7:0]    wb_adr_in;
	logic [3:0]    wb_sel_in;
	logic [31:0]   wb_dat_in;
	logic [31:0]   wb_dat_out;
	logic          wb_ack_out;
	logic          pix_we_out;
	logic [CW-1:0] pix_x_out;
	logic [CW-1:0] pix_y_out;
	logic          line_done_out;
	logic          fault_irq_out;
	logic [31:0]   rd;
	logic [31:0]   pix_q[$];
	int            ncyc;
	int            hold;
	int            num_errors;
	int            checks_done;
	lwc_top u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
		.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
		.wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
		.wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .pix_we_out(pix_we_out),
		.pix_x_out(pix_x_out), .pix_y_out(pix_y_out), .line_done_out(line_done_out),
		.fault_irq_out(fault_irq_out));
	// 200 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	// Record every written pixel as {y,x}; a frozen strobe counts once
	always @(posedge clk_in) begin
		if (pix_we_out === 1'b1 && ce_in === 1'b1) begin
			pix_q.push_back({pix_y_out, pix_x_out});
		end
	end
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xy(input int x, input int y);
		return {y[15:0], x[15:0]};
	endfunction : xy
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t %s: got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	// Classic cycle; the slave decides when to answer
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in  <= w;
		wb_adr_in <= a;
		wb_dat_in <= d;
		do begin
			@(posedge clk_in);
			n++;
		end while (wb_ack_out !== 1'b1 && n < 20);
		chk(n < 20, 32'h1, "bus answer");
		rd = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
	endtask : wb
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		wb(1'b0, a, 32'h0);
		chk(rd, exp, what);
	endtask : rchk
	task automatic win(input int xs, input int ys, input int xe, input int ye);
		wb(1'b1, A_WSTA, xy(xs, ys));
		wb(1'b1, A_WEND, xy(xe, ye));
	endtask : win
	// One extra edge after done so the last pixel is queued
	// A nonzero hold freezes the engine that many edges after the start
	task automatic run_line(input logic [31:0] p0, input logic [31:0] p1);
		wb(1'b1, A_PT0, p0);
		wb(1'b1, A_PT1, p1);
		pix_q.delete();
		wb(1'b1, A_CMD, 32'h1);
		if (hold > 0) begin
			ce_in <= 1'b0;
			repeat (hold) @(posedge clk_in);
			ce_in <= 1'b1;
		end
		ncyc = 0;
		do begin
			@(posedge clk_in);
			ncyc++;
		end while (line_done_out !== 1'b1 && ncyc < 200);
		chk(ncyc < 200, 32'h1, "line end");
		@(posedge clk_in);
	endtask : run_line
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk({wb_ack_out, pix_we_out, line_done_out, fault_irq_out}, 32'h0, "idle outs");
		rchk(A_CTRL, 32'h0, "ctrl");
		rchk(A_STAT, 32'h0, "stat");
		rchk(A_CODE, 32'h0, "code");
		wb(1'b1, 8'h3C, 32'hFFFF_FFFF);
		rchk(8'h3C, 32'h0, "unmapped");
		$display("test reset done");
	endtask : t_reset
	task automatic t_hit();
		win(5, -2, 6, 2);
		wb(1'b1, A_CTRL, 32'hD);
		run_line(xy(0, 0), xy(8, 0));
		chk(pix_q.size(), 32'h0, "hit writes");
		chk(ncyc, 32'h6, "hit abort time");
		rchk(A_CUR, xy(5, 0), "hit cur");
		rchk(A_STAT, 32'h10, "hit stat");
		chk(fault_irq_out, 32'h1, "hit irq");
		wb(1'b1, A_STAT, 32'h10);
		rchk(A_STAT, 32'h0, "pend clear");
		run_line(xy(0, 5), xy(3, 5));
		chk(pix_q.size() + ncyc, 32'h4, "hit miss run");
		rchk(A_STAT, 32'h1, "hit none");
		$display("test hit done");
	endtask : t_hit
	task automatic t_miss();
		win(0, 0, 3, 3);
		for (int en = 0; en < 2; en++) begin
			wb(1'b1, A_CTRL, en ? 32'hE : 32'h2);
			run_line(xy(1, 1), xy(6, 1));
			chk(pix_q.size(), 32'h3, "miss count");
			chk(pix_q[2], xy(3, 1), "miss last");
			chk(ncyc, 32'h4, "miss abort time");
			chk(fault_irq_out, en, "miss irq");
			rchk(A_CUR, xy(4, 1), "miss cur");
			rchk(A_STAT, 32'h11, "miss stat");
			wb(1'b1, A_STAT, 32'h10);
		end
		run_line(xy(0, 0), xy(3, 3));
		chk(pix_q.size(), 32'h4, "miss full");
		rchk(A_STAT, 32'h0, "miss in");
		$display("test miss done");
	endtask : t_miss
	task automatic t_off();
		wb(1'b1, A_CTRL, 32'h1);
		run_line(xy(0, 5), xy(2, 5));
		wb(1'b1, A_CTRL, 32'h0);
		hold = 3;
		run_line(xy(0, 0), xy(3, 0));
		hold = 0;
		chk(pix_q.size(), 32'h4, "off count");
		chk(pix_q[3], xy(3, 0), "off last");
		chk(ncyc, 32'h4, "off time");
		rchk(A_STAT, 32'h1, "off flag kept");
		$display("test off done");
	endtask : t_off
	task automatic t_clip();
		win(-2, -1, 2, 1);
		wb(1'b1, A_CTRL, 32'h3);
		run_line(xy(-4, 0), xy(4, 0));
		chk(pix_q.size(), 32'h5, "clip count");
		chk(pix_q[0], xy(-2, 0), "clip first");
		chk(pix_q[4], xy(2, 0), "clip last");
		chk(ncyc, 32'h9, "clip time");
		rchk(A_STAT, 32'h1, "clip out");
		run_line(xy(4, 1), xy(0, 1));
		chk(pix_q.size(), 32'h3, "clip edge");
		rchk(A_STAT, 32'h0, "clip in");
		$display("test clip done");
	endtask : t_clip
	task automatic t_cpw();
		int px[7] = '{-1, 4, 0, 0, 3, 0, -1};
		int py[7] = '{0, 0, -1, 4, 3, 0, 4};
		logic [31:0] oc[7] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'h0, 32'h0, 32'h9};
		win(0, 0, 3, 3);
		for (int i = 0; i < 7; i++) begin
			wb(1'b1, A_PT0, xy(px[i], py[i]));
			wb(1'b1, A_CMD, 32'h2);
			rchk(A_CODE, oc[i], "outcode");
		end
		$display("test compare done");
	endtask : t_cpw
	task automatic t_setup();
		int ax[4] = '{1, 0, 5, 2};
		int ay[4] = '{1, 2, 0, 2};
		int bx[4] = '{1, 5, 6, 2};
		int by[4] = '{3, 2, 3, 2};
		logic [31:0] st[4] = '{32'h2, 32'h9, 32'h5, 32'hA};
		logic [31:0] dl[4] = '{32'h0002_0000, 32'h0000_0005, 32'h0003_0001, 32'h0};
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, A_PT0, xy(ax[i], ay[i]));
			wb(1'b1, A_PT1, xy(bx[i], by[i]));
			wb(1'b1, A_CMD, 32'h4);
			rchk(A_STAT, st[i], "setup flags");
			rchk(A_DELTA, dl[i], "setup delta");
		end
		$display("test setup done");
	endtask : t_setup
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop
	////////////////////////////////////////////////////////////////
	// Main sequence; clock enable drops only inside one line, never on the bus
	initial begin
		{rst_n_in, wb_cyc_in, wb_stb_in, wb_we_in} = 4'h0;
		{wb_adr_in, wb_dat_in} = '0;
		wb_sel_in = 4'hF;
		ce_in = 1'b1;
		hold = 0;
		repeat (5) @(posedge clk_in);
		rst_n_in <= 1'b1;
		t_reset();
		t_hit();
		t_miss();
		t_off();
		t_clip();
		t_cpw();
		t_setup();
		report_and_stop();
	end
	// Whole run needs well under two thousand cycles
	initial begin
		repeat (5000) @(posedge clk_in);
		num_errors++;
		$display("MISMATCH t=%0t watchdog", $time);
		report_and_stop();
	end
endmodule : lwc_top_tb
